// [dv/sadc_core_model.sv]
/*
 Behavioural analog core: holds the input code from the start of convert.
 Assumes the bench supplies the analog level as a ready code on analog_i.
*/
`timescale 1ns/100ps
module sadc_core_model (
   input  wire logic       ref_clk_i,
   input  wire logic       power_i,
   input  wire logic       track_i,
   input  wire logic       convert_i,
   input  wire logic       load_i,
   input  wire logic [7:0] analog_i,
   output logic      [7:0] result_o,
   output logic            fault_o
);
   logic [7:0] held_q;
   logic [7:0] noise_q = 8'h00;
   logic       conv_q  = 1'b0;
   always @(posedge ref_clk_i) begin
      conv_q  <= convert_i;
      noise_q <= noise_q + 8'h5b;
      if (convert_i && !conv_q) begin
         held_q <= analog_i;
      end
   end
   // Junk outside the hold so a mistimed sample cannot pass
   assign result_o = (convert_i || load_i) ? held_q : noise_q;
   assign fault_o  = (track_i && convert_i) || (!power_i && (track_i || convert_i));
endmodule

// [dv/tb_sar_adc_control_window_detect.sv]
/*
 Self-checking bench for the SAR converter control block.
 Assumes the core model on the analog side and a 100 MHz system clock.
*/
`timescale 1ns/100ps
`include "sadc_params.svh"
module tb_sar_adc_control_window_detect
   import sadc_pkg::*;
;
   logic       ref_clk_i, srst_i, reg_wr_i, reg_rd_i, t3, t2, ext, comp, dif;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, core_res, analog, last_v;
   logic       pwr, trk, cnv, ld, sar, fault, armed, seen, pwr_q;
   logic [1:0] gsel;
   logic [2:0] gdec;
   int         errors, num_checks, n_conv, n_track, p, i;
   logic [24:0] corner [14] = '{{1'b0, 24'h102010}, {1'b0, 24'h102011}, {1'b0, 24'h10201f},
      {1'b0, 24'h102020}, {1'b0, 24'h201010}, {1'b0, 24'h20100f}, {1'b0, 24'h201021}, {1'b0, 24'h201020},
      {1'b1, 24'hff1000}, {1'b1, 24'hff10ff}, {1'b1, 24'hff100f}, {1'b1, 24'hff1080}, {1'b1, 24'h10ff00},
      {1'b1, 24'h10ff7f}};
   always #5 ref_clk_i = ~ref_clk_i;
   sadc_top #(.DATA_WIDTH(8), .DIV_WIDTH(5)) dut_u (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .timer3_ovf_i(t3), .timer2_ovf_i(t2), .external_start_input_i(ext),
      .companion_converter_busy_i(comp), .differential_i(dif), .core_result_i(core_res),
      .core_power_o(pwr), .core_track_o(trk), .core_convert_o(cnv), .core_result_load_o(ld),
      .sar_clock_o(sar), .pga_gain_select_o(gsel), .pga_gain_log2_plus1_o(gdec));
   sadc_core_model core_u (.ref_clk_i(ref_clk_i), .power_i(pwr), .track_i(trk), .convert_i(cnv),
      .load_i(ld), .analog_i(analog), .result_o(core_res), .fault_o(fault));
   always @(posedge ref_clk_i) begin
      pwr_q <= pwr;
      if (fault || (sar && !pwr && !pwr_q)) begin
         errors++;
         $display("[ERR] core_phase expected 0 seen 1");
      end
      if (armed && sar && cnv) n_conv++;
      if (armed && sar && trk && !cnv) n_track++;
      if (armed && ld) seen = 1'b1;
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge ref_clk_i);
      chk(nm, e, reg_rdata_o & m);
   endtask
   // Codes follow the start field: 1 timer3, 2 external rise, 3 timer2, 4 companion
   task automatic pulse(input int w);
      @(posedge ref_clk_i);
      t3   <= (w == 1);
      t2   <= (w == 3);
      comp <= (w == 4);
      if (w == 2) ext <= 1'b1;
      @(posedge ref_clk_i);
      t3   <= 1'b0;
      t2   <= 1'b0;
      comp <= 1'b0;
   endtask
   function automatic logic win(input logic [7:0] v, gt, lt, input logic d);
      logic signed [8:0] sv, sg, sl;
      sv = {d & v[7], v};
      sg = {d & gt[7], gt};
      sl = {d & lt[7], lt};
      if (sg < sl) return (sv > sg) && (sv < sl);
      return (sv < sl) || (sv > sg);
   endfunction
   task automatic conv(input logic [2:0] src, input logic tm, input logic [7:0] v, gt, lt, input logic d);
      logic [7:0] ctl;
      logic       lpx;
      int         k;
      ctl    = {1'b1, tm, 2'b00, src, 1'b0};
      lpx    = tm && (src == SADC_SRC_EXT);
      analog <= v;
      dif    <= d;
      ext    <= 1'b0;
      last_v = v;
      wr(`SADC_ADDR_UPPER, gt);
      wr(`SADC_ADDR_LOWER, lt);
      wr(`SADC_ADDR_CONTROL, ctl);
      rc("flags_clear", `SADC_ADDR_CONTROL, 8'h21, 8'h00);
      if (src != 3'h0) wr(`SADC_ADDR_CONTROL, ctl | 8'h10);
      pulse(src == 3'h1 ? 3 : 1);
      rc("no_false_start", `SADC_ADDR_CONTROL, 8'h10, 8'h00);
      if (!tm) chk("track_idle", 8'h01, {7'h00, trk});
      if (lpx) begin
         repeat (5) @(posedge ref_clk_i);
         chk("track_low", 8'h01, {7'h00, trk});
      end
      n_conv  = 0;
      n_track = 0;
      seen    = 1'b0;
      armed   = 1'b1;
      if (src == 3'h0) wr(`SADC_ADDR_CONTROL, ctl | 8'h10);
      else pulse(src > 3'h3 ? 4 : int'(src));
      rc("busy_run", `SADC_ADDR_CONTROL, 8'h10, 8'h10);
      for (k = 0; k < 3000 && !seen; k++) @(posedge ref_clk_i);
      armed = 1'b0;
      chk("load_seen", 8'h01, {7'h00, seen});
      chk("conv_ticks", 8'h08, 8'(n_conv));
      if (tm && !lpx) chk("track_ticks", 8'h03, 8'(n_track));
      rc("result", `SADC_ADDR_RESULT, 8'hff, v);
      rc("done_set", `SADC_ADDR_CONTROL, 8'h30, 8'h20);
      rc("window", `SADC_ADDR_CONTROL, 8'h01, {7'h00, win(v, gt, lt, d)});
   endtask
   task automatic finish_test;
      $display("Checks %0d, errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge ref_clk_i);
      errors++;
      finish_test;
   end
   initial begin
      {ref_clk_i, reg_wr_i, reg_rd_i, t3, t2, ext, comp, dif, armed, seen, pwr_q} = '0;
      {reg_addr_i, reg_wdata_i, analog, last_v} = '0;
      {errors, num_checks, n_conv, n_track} = '0;
      srst_i = 1'b1;
      void'($urandom(32'hf40cdb30));
      repeat (2) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      rc("cfg_rst", `SADC_ADDR_CONFIG, 8'hff, `SADC_RST_CONFIG);
      rc("res_rst", `SADC_ADDR_RESULT, 8'hff, `SADC_RST_RESULT);
      rc("up_rst", `SADC_ADDR_UPPER, 8'hff, `SADC_RST_UPPER);
      rc("low_rst", `SADC_ADDR_LOWER, 8'hff, `SADC_RST_LOWER);
      rc("ctl_rst", `SADC_ADDR_CONTROL, 8'hff, `SADC_RST_CONTROL);
      rc("unmapped", 8'h00, 8'hff, 8'h00);
      wr(`SADC_ADDR_CONTROL, 8'h10);
      rc("off_busy", `SADC_ADDR_CONTROL, 8'hff, 8'h00);
      chk("off_power", 8'h00, {7'h00, pwr});
      for (i = 0; i < 4; i++) begin
         wr(`SADC_ADDR_CONTROL, 8'h00);
         wr(`SADC_ADDR_CONFIG, {5'(13 + i * 6), 1'b1, 2'(i)});
         rc("cfg_rb", `SADC_ADDR_CONFIG, 8'hff, {5'(13 + i * 6), 1'b0, 2'(i)});
         chk("gain_sel", 8'(i), {6'h00, gsel});
         chk("gain_dec", 8'(i), {5'h00, gdec});
         wr(`SADC_ADDR_CONTROL, 8'h80);
         for (p = 0; p < 40 && !sar; p++) @(posedge ref_clk_i);
         @(posedge ref_clk_i);
         p = 1;
         while (!sar && p < 40) begin
            @(posedge ref_clk_i);
            p++;
         end
         chk("sar_period", 8'(14 + i * 6), 8'(p));
      end
      for (i = 0; i < 10; i++) conv(3'(i % 5), i > 4, 8'($urandom), 8'($urandom), 8'($urandom), 1'b0);
      for (i = 0; i < 14; i++) conv(3'h0, 1'b0, corner[i][7:0], corner[i][23:16], corner[i][15:8], corner[i][24]);
      for (i = 0; i < 24; i++) begin
         wr(`SADC_ADDR_CONFIG, {5'(13 + $urandom % 19), 1'b0, 2'($urandom)});
         conv(3'($urandom), 1'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), 1'($urandom));
      end
      analog <= ~last_v;
      repeat (100) @(posedge ref_clk_i);
      rc("result_hold", `SADC_ADDR_RESULT, 8'hff, last_v);
      rc("done_sticky", `SADC_ADDR_CONTROL, 8'h20, 8'h20);
      // Abort by disable, then a reset in the middle of a conversion
      wr(`SADC_ADDR_CONTROL, 8'h80);
      wr(`SADC_ADDR_CONTROL, 8'h90);
      rc("abort_busy", `SADC_ADDR_CONTROL, 8'h10, 8'h10);
      wr(`SADC_ADDR_CONTROL, 8'h00);
      rc("abort_flags", `SADC_ADDR_CONTROL, 8'hff, 8'h00);
      rc("abort_result", `SADC_ADDR_RESULT, 8'hff, last_v);
      wr(`SADC_ADDR_CONTROL, 8'h80);
      wr(`SADC_ADDR_CONTROL, 8'h90);
      repeat (3) @(posedge ref_clk_i);
      srst_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      rc("ctl_rst2", `SADC_ADDR_CONTROL, 8'hff, `SADC_RST_CONTROL);
      rc("res_rst2", `SADC_ADDR_RESULT, 8'hff, `SADC_RST_RESULT);
      chk("off_power2", 8'h00, {7'h00, pwr});
      finish_test;
   end
endmodule

// [hw/sadc_clkdiv.sv]
/*
 SAR clock divider: emits a one-cycle enable every (divide + 1) system clocks.
 Assumes the divide value may change at any time; a new value is taken at the next reload.
*/
`timescale 1ns/100ps
module sadc_clkdiv #(
   parameter int DIV_WIDTH = 5
) (
   // Clock and reset
   input  wire logic                 ref_clk_i,
   input  wire logic                 srst_i,
   // Control
   input  wire logic                 run_i,
   input  wire logic [DIV_WIDTH-1:0] divide_i,
   // Enable out
   output logic                      tick_o
);
   initial begin
      if (DIV_WIDTH < 1) $error("DIV_WIDTH must be at least 1");
   end

   logic [DIV_WIDTH-1:0] count_q;

   // Counting down from the field value yields field+1 clocks per tick
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || !run_i) begin
         count_q <= '0;
         tick_o  <= 1'b0;
      end else if (count_q == '0) begin
         count_q <= divide_i;
         tick_o  <= 1'b1;
      end else begin
         count_q <= count_q - 1'b1;
         tick_o  <= 1'b0;
      end
   end

   tick_period_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (tick_o && run_i && $stable(divide_i) && divide_i == '0) ##1 run_i |-> tick_o)
      else $error("Tick missing with divide of zero");
   // A nonzero divide must leave at least one quiet clock after each tick
   tick_gap_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      tick_o && run_i && divide_i != '0 && $stable(divide_i) |=> !tick_o)
      else $error("Ticks closer than the divide value allows");
endmodule

// [hw/sadc_params.svh]
/*
 Register offsets, field positions, reset values and timing counts for the
 SAR converter control block. Assumes an 8-bit register port addressed by
 its special-function addresses.
*/
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH

`define SADC_ADDR_CONFIG      8'hbc
`define SADC_ADDR_RESULT      8'hbe
`define SADC_ADDR_UPPER       8'hc4
`define SADC_ADDR_LOWER       8'hc6
`define SADC_ADDR_CONTROL     8'he8

`define SADC_RST_CONFIG       8'hf8
`define SADC_RST_RESULT       8'h00
`define SADC_RST_UPPER        8'hff
`define SADC_RST_LOWER        8'h00
`define SADC_RST_CONTROL      8'h00

`define SADC_CFG_DIV_MSB      7
`define SADC_CFG_DIV_LSB      3
`define SADC_CFG_GAIN_MSB     1
`define SADC_CFG_GAIN_LSB     0

`define SADC_CTL_ENABLE       7
`define SADC_CTL_TRACK        6
`define SADC_CTL_DONE         5
`define SADC_CTL_BUSY         4
`define SADC_CTL_SRC_MSB      3
`define SADC_CTL_SRC_LSB      1
`define SADC_CTL_WINDOW       0

`define SADC_CONV_CLOCKS      4'd8
`define SADC_TRACK_CLOCKS     4'd3
`define SADC_SAR_MAX_KHZ      7500
`define SADC_SYS_KHZ          100000

`endif

// [hw/sadc_pkg.sv]
/*
 Types shared by the SAR converter control block.
 Assumes the parameter header is included by the modules that use numbers.
*/
package sadc_pkg;
   typedef enum logic [2:0] {
      SADC_SRC_SOFT  = 3'h0,
      SADC_SRC_TMR3  = 3'h1,
      SADC_SRC_EXT   = 3'h2,
      SADC_SRC_TMR2  = 3'h3
   } sadc_src_type;

   typedef enum logic [1:0] {
      SADC_GAIN_HALF,
      SADC_GAIN_ONE,
      SADC_GAIN_TWO,
      SADC_GAIN_FOUR
   } sadc_gain_type;

   typedef enum {
      SADC_IDLE,
      SADC_TRACK,
      SADC_CONVERT
   } sadc_state_type;
endpackage

// [hw/sadc_top.sv]
/*
 Control logic of an 8-bit SAR converter: configuration, start selection,
 tracking modes, busy and done flags, result register and window compare.
 Assumes an 8-bit register port, timer overflows as one-cycle pulses, and
 a converter core that returns its result when told the conversion ended.
*/
`timescale 1ns/100ps
`include "sadc_params.svh"
module sadc_top
   import sadc_pkg::*;
#(
   parameter int DATA_WIDTH = 8,
   parameter int DIV_WIDTH  = 5
) (
   // Clock and reset
   input  wire logic                  ref_clk_i,
   input  wire logic                  srst_i,
   // Register port
   input  wire logic [7:0]            reg_addr_i,
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   input  wire logic [7:0]            reg_wdata_i,
   output logic      [7:0]            reg_rdata_o,
   // Start sources and differential select
   input  wire logic                  timer3_ovf_i,
   input  wire logic                  timer2_ovf_i,
   input  wire logic                  external_start_input_i,
   input  wire logic                  companion_converter_busy_i,
   input  wire logic                  differential_i,
   // Analog core side
   input  wire logic [DATA_WIDTH-1:0] core_result_i,
   output logic                       core_power_o,
   output logic                       core_track_o,
   output logic                       core_convert_o,
   output logic                       core_result_load_o,
   output logic                       sar_clock_o,
   output logic      [1:0]            pga_gain_select_o,
   output logic      [2:0]            pga_gain_log2_plus1_o
);
   initial begin
      if (DATA_WIDTH != 8) $error("Only 8-bit data is served");
      if (DIV_WIDTH != 5) $error("Divider field is 5 bits");
   end

   logic [7:0]            config_q;
   logic [DATA_WIDTH-1:0] result_q;
   logic [DATA_WIDTH-1:0] upper_q;
   logic [DATA_WIDTH-1:0] lower_q;
   logic                  enable_q;
   logic                  track_mode_q;
   logic                  done_q;
   logic [2:0]            src_q;
   logic                  window_q;
   sadc_state_type        state_q;
   logic [3:0]            count_q;
   logic                  ext_q;
   logic                  done_pulse_q;
   logic                  sar_tick;
   logic                  wr_cfg;
   logic                  wr_res;
   logic                  wr_up;
   logic                  wr_lo;
   logic                  wr_ctl;
   logic                  trigger;
   logic                  ext_rise;
   logic                  busy;
   logic                  win_hit;

   assign wr_cfg = reg_wr_i && reg_addr_i == `SADC_ADDR_CONFIG;
   assign wr_res = reg_wr_i && reg_addr_i == `SADC_ADDR_RESULT;
   assign wr_up  = reg_wr_i && reg_addr_i == `SADC_ADDR_UPPER;
   assign wr_lo  = reg_wr_i && reg_addr_i == `SADC_ADDR_LOWER;
   assign wr_ctl = reg_wr_i && reg_addr_i == `SADC_ADDR_CONTROL;

   sadc_clkdiv #(
      .DIV_WIDTH (DIV_WIDTH)
   ) u_div (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .run_i     (enable_q),
      .divide_i  (config_q[`SADC_CFG_DIV_MSB:`SADC_CFG_DIV_LSB]),
      .tick_o    (sar_tick)
   );

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         config_q <= `SADC_RST_CONFIG;
      end else if (wr_cfg) begin
         config_q <= reg_wdata_i & 8'hfb;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         upper_q <= `SADC_RST_UPPER;
         lower_q <= `SADC_RST_LOWER;
      end else begin
         if (wr_up) begin
            upper_q <= reg_wdata_i;
         end
         if (wr_lo) begin
            lower_q <= reg_wdata_i;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         enable_q     <= 1'b0;
         track_mode_q <= 1'b0;
         src_q        <= 3'h0;
      end else if (wr_ctl) begin
         enable_q     <= reg_wdata_i[`SADC_CTL_ENABLE];
         track_mode_q <= reg_wdata_i[`SADC_CTL_TRACK];
         src_q        <= reg_wdata_i[`SADC_CTL_SRC_MSB:`SADC_CTL_SRC_LSB];
      end
   end

   // External start is taken as synchronous; one register for edge detect
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         ext_q <= 1'b1;
      end else begin
         ext_q <= external_start_input_i;
      end
   end
   assign ext_rise = external_start_input_i && !ext_q;

   // Trigger select by source field
   always_comb begin
      trigger = 1'b0;
      if (src_q[2]) begin
         trigger = companion_converter_busy_i;
      end else begin
         case (sadc_src_type'(src_q))
            SADC_SRC_SOFT: trigger = wr_ctl && reg_wdata_i[`SADC_CTL_BUSY];
            SADC_SRC_TMR3: trigger = timer3_ovf_i;
            SADC_SRC_EXT:  trigger = ext_rise;
            SADC_SRC_TMR2: trigger = timer2_ovf_i;
            default:       trigger = 1'b0;
         endcase
      end
   end

   // Sequencer; triggers while busy are ignored, disabling aborts
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state_q      <= SADC_IDLE;
         count_q      <= 4'd0;
         done_pulse_q <= 1'b0;
      end else begin
         done_pulse_q <= 1'b0;
         case (state_q)
            SADC_IDLE: begin
               count_q <= 4'd0;
               if (enable_q && trigger) begin
                  if (track_mode_q && src_q != SADC_SRC_EXT) begin
                     state_q <= SADC_TRACK;
                  end else begin
                     state_q <= SADC_CONVERT;
                  end
               end
            end
            SADC_TRACK: begin
               if (!enable_q) begin
                  state_q <= SADC_IDLE;
               end else if (sar_tick) begin
                  if (count_q == `SADC_TRACK_CLOCKS - 4'd1) begin
                     count_q <= 4'd0;
                     state_q <= SADC_CONVERT;
                  end else begin
                     count_q <= count_q + 4'd1;
                  end
               end
            end
            SADC_CONVERT: begin
               if (!enable_q) begin
                  state_q <= SADC_IDLE;
               end else if (sar_tick) begin
                  if (count_q == `SADC_CONV_CLOCKS - 4'd1) begin
                     count_q      <= 4'd0;
                     state_q      <= SADC_IDLE;
                     done_pulse_q <= 1'b1;
                  end else begin
                     count_q <= count_q + 4'd1;
                  end
               end
            end
            default: state_q <= SADC_IDLE;
         endcase
      end
   end

   // Busy covers the low-power tracking period as part of the conversion
   assign busy = state_q != SADC_IDLE;

   // Tick count over one whole conversion, kept apart from the sequencer count
   logic [3:0] busy_ticks_q;
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || state_q == SADC_IDLE) begin
         busy_ticks_q <= 4'd0;
      end else if (sar_tick) begin
         busy_ticks_q <= busy_ticks_q + 4'd1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         result_q <= `SADC_RST_RESULT;
      end else if (done_pulse_q) begin
         result_q <= core_result_i;
      end else if (wr_res) begin
         result_q <= reg_wdata_i;
      end
   end

   // Window compare on the fresh core result, same cycle as result load
   always_comb begin
      logic signed [8:0] r;
      logic signed [8:0] u;
      logic signed [8:0] l;
      r = {differential_i & core_result_i[7], core_result_i};
      u = {differential_i & upper_q[7], upper_q};
      l = {differential_i & lower_q[7], lower_q};
      if (u < l) begin
         win_hit = (r > u) && (r < l);
      end else begin
         win_hit = (r < l) || (r > u);
      end
   end

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         done_q   <= 1'b0;
         window_q <= 1'b0;
      end else begin
         if (done_pulse_q) begin
            done_q <= 1'b1;
         end else if (wr_ctl && !reg_wdata_i[`SADC_CTL_DONE]) begin
            done_q <= 1'b0;
         end
         if (done_pulse_q && win_hit) begin
            window_q <= 1'b1;
         end else if (wr_ctl && !reg_wdata_i[`SADC_CTL_WINDOW]) begin
            window_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `SADC_ADDR_CONFIG:  reg_rdata_o <= config_q;
            `SADC_ADDR_RESULT:  reg_rdata_o <= result_q;
            `SADC_ADDR_UPPER:   reg_rdata_o <= upper_q;
            `SADC_ADDR_LOWER:   reg_rdata_o <= lower_q;
            `SADC_ADDR_CONTROL: reg_rdata_o <= {enable_q, track_mode_q, done_q, busy, src_q, window_q};
            default:            reg_rdata_o <= 8'h00;
         endcase
      end
   end

   always_comb begin
      case (sadc_gain_type'(config_q[`SADC_CFG_GAIN_MSB:`SADC_CFG_GAIN_LSB]))
         SADC_GAIN_HALF: pga_gain_log2_plus1_o = 3'h0;
         SADC_GAIN_ONE:  pga_gain_log2_plus1_o = 3'h1;
         SADC_GAIN_TWO:  pga_gain_log2_plus1_o = 3'h2;
         SADC_GAIN_FOUR: pga_gain_log2_plus1_o = 3'h3;
         default:        pga_gain_log2_plus1_o = 3'h1;
      endcase
   end

   assign pga_gain_select_o  = config_q[`SADC_CFG_GAIN_MSB:`SADC_CFG_GAIN_LSB];
   assign core_power_o       = enable_q;
   // Gated by enable so the core never sees convert in the cycle power drops
   assign core_convert_o     = enable_q && state_q == SADC_CONVERT;
   // Normal mode tracks whenever idle; low power tracks in the track phase or, with the external source, while idle and the pin is low
   assign core_track_o       = enable_q && (track_mode_q ?
                               (state_q == SADC_TRACK ||
                                (state_q == SADC_IDLE && src_q == SADC_SRC_EXT && !external_start_input_i)) :
                               state_q != SADC_CONVERT);
   assign core_result_load_o = done_pulse_q;
   assign sar_clock_o        = sar_tick;

   done_on_fall_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      $fell(busy) && enable_q |-> ##1 done_q)
      else $error("Done flag not set after busy fell");
   done_sticky_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      done_q && !(wr_ctl && !reg_wdata_i[`SADC_CTL_DONE]) |=> done_q)
      else $error("Done flag cleared without software");
   done_clear_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !done_pulse_q && wr_ctl && !reg_wdata_i[`SADC_CTL_DONE] |=> !done_q)
      else $error("Done flag not cleared by a write of zero");
   soft_start_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      state_q == SADC_IDLE && enable_q && wr_ctl && reg_wdata_i[`SADC_CTL_BUSY] && src_q == 3'h0 |=> busy)
      else $error("Busy write did not start conversion");
   no_start_off_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      state_q == SADC_IDLE && !enable_q |=> !busy)
      else $error("Conversion started while disabled");
   disable_abort_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !enable_q |=> state_q == SADC_IDLE && !done_pulse_q)
      else $error("Disabled converter kept running");
   ext_start_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      state_q == SADC_IDLE && enable_q && src_q == SADC_SRC_EXT && ext_rise |=> state_q == SADC_CONVERT)
      else $error("External rising edge did not start conversion");
   track_len_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      state_q == SADC_TRACK && enable_q && !(sar_tick && count_q == `SADC_TRACK_CLOCKS - 4'd1)
      |=> state_q == SADC_TRACK)
      else $error("Low power tracking ended early");
   conv_len_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      state_q == SADC_CONVERT && sar_tick && count_q < `SADC_CONV_CLOCKS - 4'd1
      |=> state_q == SADC_CONVERT || !enable_q)
      else $error("Conversion shorter than eight SAR clocks");
   tick_total_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      done_pulse_q |-> busy_ticks_q == ((track_mode_q && src_q != SADC_SRC_EXT) ?
         `SADC_CONV_CLOCKS + `SADC_TRACK_CLOCKS : `SADC_CONV_CLOCKS))
      else $error("Conversion took the wrong number of SAR clocks");
   result_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !done_pulse_q && !wr_res |=> $stable(result_q))
      else $error("Result changed without a completion");
   result_load_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      done_pulse_q |=> result_q == $past(core_result_i))
      else $error("Result not loaded at completion");
   window_set_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      done_pulse_q && win_hit |=> window_q)
      else $error("Window flag not set on a match");
   normal_track_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      enable_q && !track_mode_q && state_q != SADC_CONVERT |-> core_track_o)
      else $error("Normal mode not tracking while idle");
endmodule
